// ### verilog/i2cc_cfg.svh
// Constants for the bus interface control layer.
`ifndef I2CC_CFG_SVH
`define I2CC_CFG_SVH
`define I2CC_CLK_SEL_W 5
`define I2CC_IRQ_LVL_W 2
`define I2CC_IRQ_LVL_RST 2'h3
`define I2CC_IRQ_VEC_W 5
`define I2CC_IRQ_VECTOR 5'h10
`define I2CC_NUM_FLAGS 5
`define I2CC_F_XFER 0
`define I2CC_F_BUSERR 1
`define I2CC_F_STOP 2
`define I2CC_F_ARB 3
`define I2CC_F_WAKE 4
`endif

// ### verilog/i2cc_pkg.sv
// Types shared by the bus interface control layer.
package i2cc_pkg;
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_SLAVE = 2'b01,
		MODE_MASTER = 2'b10
	} i2cc_mode_e;
	typedef enum logic [1:0] {
		ACK_NONE = 2'b00,
		ACK_ADDR = 2'b01,
		ACK_GENCALL = 2'b10,
		ACK_DATA = 2'b11
	} i2cc_ack_e;
	typedef struct packed {
		logic opEnable;
		logic [4:0] shiftClkSel;
		logic divMBypass;
	} i2cc_clk_ctrl_s;
	typedef struct packed {
		logic addrAckDisable;
		logic xferDoneTimingSel;
		logic arbLostIrqEn;
		logic arbLostFlag;
		logic stopDetIrqEn;
		logic stopDetFlag;
		logic wakeupEn;
		logic wakeupFlag;
	} i2cc_ctrl_a_s;
	typedef struct packed {
		logic masterSlaveSelect;
		logic restartGen;
		logic dataAckEnable;
		logic gencallAckEnable;
		logic xferDoneIrqEn;
		logic xferDoneFlag;
		logic busErrIrqEn;
		logic busErrFlag;
	} i2cc_ctrl_b_s;
	typedef struct packed {
		logic sclEighth;
		logic sclNinth;
		logic busErr;
		logic stopDet;
		logic arbLost;
		logic startDet;
		logic transmitting;
		logic firstByte;
		logic standby;
		logic addrMatch;
		logic gencallRx;
		i2cc_ack_e ackSlot;
	} i2cc_bus_ev_s;
	typedef struct packed {
		logic flag;
	} i2cc_flag_state_s;
	typedef struct packed {
		i2cc_clk_ctrl_s clk;
		logic addrAckDisable;
		logic xferDoneTimingSel;
		logic arbLostIrqEn;
		logic stopDetIrqEn;
		logic wakeupEn;
		logic masterSlaveSelect;
		logic dataAckEnable;
		logic gencallAckEnable;
		logic xferDoneIrqEn;
		logic busErrIrqEn;
		logic [1:0] irqLevel;
		i2cc_mode_e mode;
		logic startReq;
		logic restartReq;
		logic stopReq;
		logic ackDrive;
		logic irqOut;
		logic [4:0] irqVector;
	} i2cc_top_state_s;
endpackage

// ### verilog/i2cc_irq_flag.sv
// One sticky interrupt request flag, set by hardware and cleared by a zero write.
`timescale 1ns/1ps
`default_nettype none
module i2cc_irq_flag (
	input wire logic core_clk, // System clock.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic clkEn, // Freezes the flag while low.
	input wire logic setEv, // Hardware event pulse.
	input wire logic clrWr, // Software wrote zero to the flag.
	input wire logic holdClr, // Interface disabled, flag forced low.
	output logic flag // Flag value.
);
	i2cc_pkg::i2cc_flag_state_s s_reg;
	i2cc_pkg::i2cc_flag_state_s s_next;

	always_comb begin
		s_next = s_reg;
		if (holdClr) begin
			s_next.flag = 1'b0;
		end else if (setEv) begin
			s_next.flag = 1'b1;
		end else if (clrWr) begin
			s_next.flag = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else if (clkEn) begin
			s_reg <= s_next;
		end
	end

	assign flag = s_reg.flag;

	property p_setWins;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && setEv && !holdClr) |=> flag;
	endproperty
	a_setWins: assert property (p_setWins) else $error("flag lost a set event");

	property p_zeroClears;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && clrWr && !setEv) |=> !flag;
	endproperty
	a_zeroClears: assert property (p_zeroClears) else $error("zero write did not clear");

	property p_onlyEventSets;
		@(posedge core_clk) disable iff (sys_rst)
		(!flag && !(clkEn && setEv)) |=> !flag;
	endproperty
	a_onlyEventSets: assert property (p_onlyEventSets) else $error("flag rose without event");
endmodule
`default_nettype wire

// ### verilog/i2cc_ctrl.sv
// Control, acknowledge and interrupt layer of the two-wire bus interface.
//
// Contract
// - Interface inactive while operation enable is 0; runs once it is set.
// - Writing 1 to master select starts a master transfer; 0 selects slave.
// - A five-bit clock select field picks the shift clock rate.
// - Divider bypass set makes the clock generator skip the m divider.
// - Own address is acknowledged only while address ack disable is 0.
// - Received data is acknowledged only while data ack enable is 1.
// - General call address is acknowledged only while gencall ack enable is 1.
// - Writing 1 to restart generation issues a repeated start; the code issues it only while master select is 1 and stays 1.
// - Receive completion rises on the ninth SCL, or eighth with timing select.
// - Transfer completion request forwarded only while its enable is 1.
// - Writing 0 to the transfer completion flag clears it.
// - Bus error request forwarded only while its enable is 1.
// - Writing 0 to the bus error flag clears it.
// - Stop detection request forwarded only while its enable is 1.
// - Writing 0 to the stop detection flag clears it.
// - Arbitration lost request forwarded only while its enable is 1.
// - Writing 0 to the arbitration lost flag clears it.
// - Wakeup enable bit switches the start-condition wakeup interrupt on or off.
// - Writing 0 to the wakeup flag clears it.
// - Interrupt served at vector 16 with level from the level register.
// - Eighth-cycle choice applies only to data reception, else ninth.
// - Disabling clears listed control bits, second register mostly, and all flags except the bus error flag.
// - In standby with wakeup enabled, a start condition sets the wakeup flag.
`include "i2cc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module i2cc_ctrl (
	input wire logic core_clk, // System clock, 40 MHz.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic clkEn, // Freezes all state while low.
	input wire logic clkCtrlWr, // Write strobe for clock control.
	input wire i2cc_pkg::i2cc_clk_ctrl_s clkCtrlIn, // Clock control write data.
	input wire logic ctrlAWr, // Write strobe for bus control A.
	input wire i2cc_pkg::i2cc_ctrl_a_s ctrlAIn, // Bus control A write data.
	input wire logic ctrlBWr, // Write strobe for bus control B.
	input wire i2cc_pkg::i2cc_ctrl_b_s ctrlBIn, // Bus control B write data.
	input wire logic irqLevelWr, // Write strobe for interrupt level.
	input wire logic [`I2CC_IRQ_LVL_W-1:0] irqLevelIn, // Interrupt level write data.
	input wire i2cc_pkg::i2cc_bus_ev_s busEv, // Events from the protocol engine.
	output i2cc_pkg::i2cc_clk_ctrl_s clkCtrlOut, // Clock control readback.
	output i2cc_pkg::i2cc_ctrl_a_s ctrlAOut, // Bus control A readback.
	output i2cc_pkg::i2cc_ctrl_b_s ctrlBOut, // Bus control B readback.
	output logic [`I2CC_IRQ_LVL_W-1:0] irqLevelOut, // Interrupt level.
	output logic [`I2CC_IRQ_VEC_W-1:0] irqVectorOut, // Interrupt vector number.
	output i2cc_pkg::i2cc_mode_e modeOut, // Operating mode.
	output logic startReq, // Pulse: generate start as master.
	output logic restartReq, // Pulse: generate repeated start.
	output logic stopReq, // Pulse: generate stop.
	output logic ackDrive, // Drive acknowledge in the current slot.
	output logic irqOut // Combined interrupt request.
);
	i2cc_pkg::i2cc_top_state_s s_reg;
	i2cc_pkg::i2cc_top_state_s s_next;
	logic [`I2CC_NUM_FLAGS-1:0] setV;
	logic [`I2CC_NUM_FLAGS-1:0] clrV;
	logic [`I2CC_NUM_FLAGS-1:0] holdV;
	logic [`I2CC_NUM_FLAGS-1:0] enV;
	logic [`I2CC_NUM_FLAGS-1:0] flagV;
	logic opEn;
	logic opEnNext;
	logic rxData;

	assign opEn = s_reg.clk.opEnable;
	// All flags but the bus error flag drop at the same edge as the control bits when the interface is switched off.
	assign opEnNext = clkCtrlWr ? clkCtrlIn.opEnable : opEn;
	assign rxData = !busEv.transmitting && !busEv.firstByte;

	// Flag events. Nothing is set while the interface is disabled.
	always_comb begin
		setV = '0;
		if (opEn) begin
			if (rxData && s_reg.xferDoneTimingSel) begin
				setV[`I2CC_F_XFER] = busEv.sclEighth;
			end else begin
				setV[`I2CC_F_XFER] = busEv.sclNinth;
			end
			setV[`I2CC_F_BUSERR] = busEv.busErr;
			setV[`I2CC_F_STOP] = busEv.stopDet;
			setV[`I2CC_F_ARB] = busEv.arbLost;
			setV[`I2CC_F_WAKE] = busEv.startDet && busEv.standby && s_reg.wakeupEn;
		end
	end

	// Zero writes clear; ones are ignored by the flag cells.
	always_comb begin
		clrV = '0;
		clrV[`I2CC_F_XFER] = ctrlBWr && opEn && !ctrlBIn.xferDoneFlag;
		clrV[`I2CC_F_BUSERR] = ctrlBWr && !ctrlBIn.busErrFlag;
		clrV[`I2CC_F_STOP] = ctrlAWr && opEn && !ctrlAIn.stopDetFlag;
		clrV[`I2CC_F_ARB] = ctrlAWr && opEn && !ctrlAIn.arbLostFlag;
		clrV[`I2CC_F_WAKE] = ctrlAWr && opEn && !ctrlAIn.wakeupFlag;
	end

	always_comb begin
		holdV = {`I2CC_NUM_FLAGS{!opEnNext}};
		holdV[`I2CC_F_BUSERR] = 1'b0;
		enV = '0;
		enV[`I2CC_F_XFER] = s_reg.xferDoneIrqEn;
		enV[`I2CC_F_BUSERR] = s_reg.busErrIrqEn;
		enV[`I2CC_F_STOP] = s_reg.stopDetIrqEn;
		enV[`I2CC_F_ARB] = s_reg.arbLostIrqEn;
		enV[`I2CC_F_WAKE] = s_reg.wakeupEn;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `I2CC_NUM_FLAGS; gi++) begin : g_flag
			i2cc_irq_flag u_flag (
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.clkEn(clkEn),
				.setEv(setV[gi]),
				.clrWr(clrV[gi]),
				.holdClr(holdV[gi]),
				.flag(flagV[gi])
			);
		end
	endgenerate

	always_comb begin
		s_next = s_reg;
		s_next.startReq = 1'b0;
		s_next.restartReq = 1'b0;
		s_next.stopReq = 1'b0;
		if (clkCtrlWr) begin
			s_next.clk = clkCtrlIn;
		end
		if (ctrlAWr && opEn) begin
			s_next.addrAckDisable = ctrlAIn.addrAckDisable;
			s_next.xferDoneTimingSel = ctrlAIn.xferDoneTimingSel;
			s_next.arbLostIrqEn = ctrlAIn.arbLostIrqEn;
			s_next.stopDetIrqEn = ctrlAIn.stopDetIrqEn;
			s_next.wakeupEn = ctrlAIn.wakeupEn;
		end
		if (ctrlBWr) begin
			s_next.busErrIrqEn = ctrlBIn.busErrIrqEn;
			if (opEn) begin
				s_next.masterSlaveSelect = ctrlBIn.masterSlaveSelect;
				s_next.dataAckEnable = ctrlBIn.dataAckEnable;
				s_next.gencallAckEnable = ctrlBIn.gencallAckEnable;
				s_next.xferDoneIrqEn = ctrlBIn.xferDoneIrqEn;
				s_next.startReq = ctrlBIn.masterSlaveSelect && !s_reg.masterSlaveSelect;
				s_next.stopReq = !ctrlBIn.masterSlaveSelect && s_reg.masterSlaveSelect;
				// A repeated start only makes sense while already master.
				s_next.restartReq = ctrlBIn.restartGen && ctrlBIn.masterSlaveSelect
					&& s_reg.masterSlaveSelect;
			end
		end
		if (irqLevelWr) begin
			s_next.irqLevel = irqLevelIn;
		end
		if (!s_next.clk.opEnable) begin
			s_next.addrAckDisable = 1'b0;
			s_next.xferDoneTimingSel = 1'b0;
			s_next.wakeupEn = 1'b0;
			s_next.masterSlaveSelect = 1'b0;
			s_next.dataAckEnable = 1'b0;
			s_next.gencallAckEnable = 1'b0;
			s_next.xferDoneIrqEn = 1'b0;
			s_next.startReq = 1'b0;
			s_next.restartReq = 1'b0;
			s_next.stopReq = 1'b0;
		end
		case ({s_next.clk.opEnable, s_next.masterSlaveSelect})
			2'b10: s_next.mode = i2cc_pkg::MODE_SLAVE;
			2'b11: s_next.mode = i2cc_pkg::MODE_MASTER;
			default: s_next.mode = i2cc_pkg::MODE_OFF;
		endcase
		case (busEv.ackSlot)
			i2cc_pkg::ACK_ADDR: s_next.ackDrive = opEn && busEv.addrMatch
				&& !s_reg.addrAckDisable;
			i2cc_pkg::ACK_GENCALL: s_next.ackDrive = opEn && busEv.gencallRx
				&& s_reg.gencallAckEnable;
			i2cc_pkg::ACK_DATA: s_next.ackDrive = opEn && s_reg.dataAckEnable;
			default: s_next.ackDrive = 1'b0;
		endcase
		s_next.irqOut = |(flagV & enV);
		s_next.irqVector = `I2CC_IRQ_VECTOR;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
			s_reg.irqLevel <= `I2CC_IRQ_LVL_RST;
			s_reg.irqVector <= `I2CC_IRQ_VECTOR;
		end else if (clkEn) begin
			s_reg <= s_next;
		end
	end

	always_comb begin
		clkCtrlOut = s_reg.clk;
		ctrlAOut.addrAckDisable = s_reg.addrAckDisable;
		ctrlAOut.xferDoneTimingSel = s_reg.xferDoneTimingSel;
		ctrlAOut.arbLostIrqEn = s_reg.arbLostIrqEn;
		ctrlAOut.arbLostFlag = flagV[`I2CC_F_ARB];
		ctrlAOut.stopDetIrqEn = s_reg.stopDetIrqEn;
		ctrlAOut.stopDetFlag = flagV[`I2CC_F_STOP];
		ctrlAOut.wakeupEn = s_reg.wakeupEn;
		ctrlAOut.wakeupFlag = flagV[`I2CC_F_WAKE];
		ctrlBOut.masterSlaveSelect = s_reg.masterSlaveSelect;
		ctrlBOut.restartGen = s_reg.restartReq;
		ctrlBOut.dataAckEnable = s_reg.dataAckEnable;
		ctrlBOut.gencallAckEnable = s_reg.gencallAckEnable;
		ctrlBOut.xferDoneIrqEn = s_reg.xferDoneIrqEn;
		ctrlBOut.xferDoneFlag = flagV[`I2CC_F_XFER];
		ctrlBOut.busErrIrqEn = s_reg.busErrIrqEn;
		ctrlBOut.busErrFlag = flagV[`I2CC_F_BUSERR];
	end

	assign irqLevelOut = s_reg.irqLevel;
	assign irqVectorOut = s_reg.irqVector;
	assign modeOut = s_reg.mode;
	assign startReq = s_reg.startReq;
	assign restartReq = s_reg.restartReq;
	assign stopReq = s_reg.stopReq;
	assign ackDrive = s_reg.ackDrive;
	assign irqOut = s_reg.irqOut;

	property p_startOnSelect;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && opEn && !clkCtrlWr && ctrlBWr && ctrlBIn.masterSlaveSelect
			&& !s_reg.masterSlaveSelect) |=> (startReq && modeOut == i2cc_pkg::MODE_MASTER);
	endproperty
	a_startOnSelect: assert property (p_startOnSelect) else $error("no start on select");

	property p_disableClears;
		@(posedge core_clk) disable iff (sys_rst)
		!opEn |-> (!s_reg.wakeupEn && !s_reg.masterSlaveSelect && !flagV[`I2CC_F_XFER]
			&& modeOut == i2cc_pkg::MODE_OFF);
	endproperty
	a_disableClears: assert property (p_disableClears) else $error("disable left bits set");

	property p_irqCombine;
		@(posedge core_clk) disable iff (sys_rst)
		clkEn |=> (irqOut == |($past(flagV) & $past(enV)));
	endproperty
	a_irqCombine: assert property (p_irqCombine) else $error("combined irq wrong");

	property p_eighthRx;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && opEn && !clkCtrlWr && busEv.sclEighth && rxData
			&& s_reg.xferDoneTimingSel) |=> ctrlBOut.xferDoneFlag;
	endproperty
	a_eighthRx: assert property (p_eighthRx) else $error("no eighth-cycle completion");

	property p_eighthTxIgnored;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && !flagV[`I2CC_F_XFER] && busEv.sclEighth && !busEv.sclNinth
			&& busEv.transmitting) |=> !ctrlBOut.xferDoneFlag;
	endproperty
	a_eighthTxIgnored: assert property (p_eighthTxIgnored) else $error("eighth set on tx");

	property p_addrAck;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && busEv.ackSlot == i2cc_pkg::ACK_ADDR && busEv.addrMatch && opEn)
			|=> (ackDrive == !$past(s_reg.addrAckDisable));
	endproperty
	a_addrAck: assert property (p_addrAck) else $error("address ack wrong");

	property p_gencallAck;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && busEv.ackSlot == i2cc_pkg::ACK_GENCALL && !s_reg.gencallAckEnable)
			|=> !ackDrive;
	endproperty
	a_gencallAck: assert property (p_gencallAck) else $error("gencall ack while off");

	property p_dataAck;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && busEv.ackSlot == i2cc_pkg::ACK_DATA) |=> (ackDrive == $past(s_reg.dataAckEnable));
	endproperty
	a_dataAck: assert property (p_dataAck) else $error("data ack wrong");

	property p_wakeup;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && opEn && !clkCtrlWr && s_reg.wakeupEn && busEv.standby && busEv.startDet)
			|=> ctrlAOut.wakeupFlag;
	endproperty
	a_wakeup: assert property (p_wakeup) else $error("no wakeup on start");

	property p_vector;
		@(posedge core_clk) disable iff (sys_rst)
		irqVectorOut == `I2CC_IRQ_VECTOR;
	endproperty
	a_vector: assert property (p_vector) else $error("wrong vector");

	property p_irqGate;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && !(|(flagV & enV))) |=> !irqOut;
	endproperty
	a_irqGate: assert property (p_irqGate) else $error("irq without enabled flag");

	property p_clearXfer;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && ctrlBWr && opEn && !ctrlBIn.xferDoneFlag && !setV[`I2CC_F_XFER])
			|=> !ctrlBOut.xferDoneFlag;
	endproperty
	a_clearXfer: assert property (p_clearXfer) else $error("completion flag kept");

	property p_clearBusErr;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && ctrlBWr && !ctrlBIn.busErrFlag && !setV[`I2CC_F_BUSERR])
			|=> !ctrlBOut.busErrFlag;
	endproperty
	a_clearBusErr: assert property (p_clearBusErr) else $error("bus error flag kept");

	property p_clearStop;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && ctrlAWr && opEn && !ctrlAIn.stopDetFlag && !setV[`I2CC_F_STOP])
			|=> !ctrlAOut.stopDetFlag;
	endproperty
	a_clearStop: assert property (p_clearStop) else $error("stop flag kept");

	property p_clearArb;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && ctrlAWr && opEn && !ctrlAIn.arbLostFlag && !setV[`I2CC_F_ARB])
			|=> !ctrlAOut.arbLostFlag;
	endproperty
	a_clearArb: assert property (p_clearArb) else $error("arbitration flag kept");

	property p_clearWake;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && ctrlAWr && opEn && !ctrlAIn.wakeupFlag && !setV[`I2CC_F_WAKE])
			|=> !ctrlAOut.wakeupFlag;
	endproperty
	a_clearWake: assert property (p_clearWake) else $error("wakeup flag kept");

	property p_restart;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && opEn && !clkCtrlWr && ctrlBWr && ctrlBIn.restartGen
			&& ctrlBIn.masterSlaveSelect && s_reg.masterSlaveSelect) |=> restartReq;
	endproperty
	a_restart: assert property (p_restart) else $error("no repeated start");

	property p_clkLoad;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && clkCtrlWr) |=> (clkCtrlOut == $past(clkCtrlIn));
	endproperty
	a_clkLoad: assert property (p_clkLoad) else $error("clock control not loaded");

	property p_stopOnSlave;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && opEn && !clkCtrlWr && ctrlBWr && !ctrlBIn.masterSlaveSelect
			&& s_reg.masterSlaveSelect) |=> (stopReq && modeOut == i2cc_pkg::MODE_SLAVE);
	endproperty
	a_stopOnSlave: assert property (p_stopOnSlave) else $error("no slave select");

	property p_offOnDisable;
		@(posedge core_clk) disable iff (sys_rst)
		(clkEn && clkCtrlWr && !clkCtrlIn.opEnable)
			|=> (modeOut == i2cc_pkg::MODE_OFF && !startReq && !restartReq);
	endproperty
	a_offOnDisable: assert property (p_offOnDisable) else $error("disable left mode on");
endmodule
`default_nettype wire

// ### verif/i2cc_bus_model.sv
// Behavioural stand-in for the protocol engine and the far bus devices.
`timescale 1ns/1ps
`default_nettype none
module i2cc_bus_model (
	input wire i2cc_pkg::i2cc_bus_ev_s evTmpl, // Event pattern wanted.
	input wire logic evGo, // Present the pattern in this cycle.
	output var i2cc_pkg::i2cc_bus_ev_s busEv // Events towards the block.
);
	// Pulses and the acknowledge slot last only for the requested cycle; levels persist.
	always_comb begin
		busEv = evTmpl;
		if (!evGo) begin
			{busEv.sclEighth, busEv.sclNinth, busEv.busErr} = 3'h0;
			{busEv.stopDet, busEv.arbLost, busEv.startDet} = 3'h0;
			busEv.ackSlot = i2cc_pkg::ACK_NONE;
		end
	end
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the control and interrupt layer.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk, sys_rst, clkEn, clkCtrlWr, ctrlAWr, ctrlBWr, irqLevelWr, evGo;
	logic [1:0] irqLevelIn;
	logic [1:0] irqLevelOut;
	logic [4:0] irqVectorOut;
	logic startReq, restartReq, stopReq, ackDrive, irqOut;
	i2cc_pkg::i2cc_clk_ctrl_s clkCtrlIn, clkCtrlOut, shC;
	i2cc_pkg::i2cc_ctrl_a_s ctrlAIn, ctrlAOut, shA;
	i2cc_pkg::i2cc_ctrl_b_s ctrlBIn, ctrlBOut, shB;
	i2cc_pkg::i2cc_bus_ev_s ev, evB, busEv;
	i2cc_pkg::i2cc_mode_e modeOut;
	int n_errors = 0;
	int checks = 0;
	i2cc_bus_model i_bus (.evTmpl(ev), .evGo(evGo), .busEv(busEv));
	i2cc_ctrl i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
		.clkCtrlWr(clkCtrlWr), .clkCtrlIn(clkCtrlIn), .ctrlAWr(ctrlAWr), .ctrlAIn(ctrlAIn),
		.ctrlBWr(ctrlBWr), .ctrlBIn(ctrlBIn), .irqLevelWr(irqLevelWr), .irqLevelIn(irqLevelIn),
		.busEv(busEv), .clkCtrlOut(clkCtrlOut), .ctrlAOut(ctrlAOut), .ctrlBOut(ctrlBOut),
		.irqLevelOut(irqLevelOut), .irqVectorOut(irqVectorOut), .modeOut(modeOut),
		.startReq(startReq), .restartReq(restartReq), .stopReq(stopReq),
		.ackDrive(ackDrive), .irqOut(irqOut));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Lets one idle edge pass, then writes one register image; readback settles by the next fall.
	task automatic wr(input int r);
		@(negedge core_clk);
		clkCtrlIn = shC;
		ctrlAIn = shA;
		ctrlBIn = shB;
		clkCtrlWr = (r == 0);
		ctrlAWr = (r == 1);
		ctrlBWr = (r == 2);
		@(negedge core_clk);
		{clkCtrlWr, ctrlAWr, ctrlBWr} = 3'h0;
	endtask
	// Presents the staged pattern for one edge, after one idle edge.
	task automatic pulse();
		@(negedge core_clk);
		ev = evB;
		evGo = 1'b1;
		@(negedge core_clk);
		evGo = 1'b0;
		evB = '0;
	endtask
	task automatic fire(input int k);
		evB.sclNinth = (k == 0);
		evB.busErr = (k == 1);
		evB.stopDet = (k == 2);
		evB.arbLost = (k == 3);
		evB.startDet = (k == 4);
		evB.standby = 1'b1;
		pulse();
	endtask
	task automatic setEn(input int k, input logic v);
		case (k)
			0: shB.xferDoneIrqEn = v;
			1: shB.busErrIrqEn = v;
			2: shA.stopDetIrqEn = v;
			3: shA.arbLostIrqEn = v;
			default: shA.wakeupEn = v;
		endcase
		wr(k < 2 ? 2 : 1);
	endtask
	// Shadow images keep every flag at one so that ordinary writes leave flags alone.
	task automatic clr(input int k);
		i2cc_pkg::i2cc_ctrl_a_s a;
		i2cc_pkg::i2cc_ctrl_b_s b;
		a = shA;
		b = shB;
		case (k)
			0: shB.xferDoneFlag = 1'b0;
			1: shB.busErrFlag = 1'b0;
			2: shA.stopDetFlag = 1'b0;
			3: shA.arbLostFlag = 1'b0;
			default: shA.wakeupFlag = 1'b0;
		endcase
		wr(k < 2 ? 2 : 1);
		shA = a;
		shB = b;
	endtask
	function automatic logic flagOf(input int k);
		case (k)
			0: return ctrlBOut.xferDoneFlag;
			1: return ctrlBOut.busErrFlag;
			2: return ctrlAOut.stopDetFlag;
			3: return ctrlAOut.arbLostFlag;
			default: return ctrlAOut.wakeupFlag;
		endcase
	endfunction
	initial begin
		repeat (3000) @(posedge core_clk);
		n_errors++;
		wrap_up();
	end
	initial begin
		sys_rst = 1'b1;
		clkEn = 1'b1;
		{clkCtrlWr, ctrlAWr, ctrlBWr, irqLevelWr, evGo} = 5'h0;
		irqLevelIn = 2'h0;
		ev = '0;
		evB = '0;
		shC = '0;
		shA = 8'h95;
		shB = 8'h05;
		clkCtrlIn = '0;
		ctrlAIn = '0;
		ctrlBIn = '0;
		repeat (12) @(negedge core_clk);
		sys_rst = 1'b0;
		chk("level", 8'(irqLevelOut), 8'h03);
		chk("vector", 8'(irqVectorOut), 8'h10);
		chk("mode", 8'(modeOut), 8'h00);
		irqLevelIn = 2'h1;
		irqLevelWr = 1'b1;
		@(negedge core_clk);
		irqLevelWr = 1'b0;
		chk("level", 8'(irqLevelOut), 8'h01);
		wr(1);
		chk("ctrlA", ctrlAOut, 8'h00);
		shA = 8'h15;
		shC = 7'h6b;
		wr(0);
		chk("clkCtrl", 8'(clkCtrlOut), 8'h6b);
		$display("test reset and enable done");
		shB.masterSlaveSelect = 1'b1;
		wr(2);
		chk("start", 8'(startReq), 8'h01);
		chk("mode", 8'(modeOut), 8'(i2cc_pkg::MODE_MASTER));
		@(negedge core_clk);
		chk("start", 8'(startReq), 8'h00);
		shB.restartGen = 1'b1;
		wr(2);
		shB.restartGen = 1'b0;
		chk("restart", 8'(restartReq), 8'h01);
		shB.masterSlaveSelect = 1'b0;
		wr(2);
		chk("stop", 8'(stopReq), 8'h01);
		chk("mode", 8'(modeOut), 8'(i2cc_pkg::MODE_SLAVE));
		$display("test mode done");
		for (int v = 0; v < 2; v++) begin
			shA.addrAckDisable = v[0];
			shB.dataAckEnable = !v[0];
			shB.gencallAckEnable = !v[0];
			wr(1);
			wr(2);
			for (int s = 1; s < 4; s++) begin
				evB.addrMatch = 1'b1;
				evB.gencallRx = 1'b1;
				evB.ackSlot = i2cc_pkg::i2cc_ack_e'(s[1:0]);
				pulse();
				chk("ackDrive", 8'(ackDrive), 8'(!v[0]));
			end
		end
		$display("test acknowledge done");
		for (int k = 0; k < 5; k++) begin
			fire(k);
			chk("flag", 8'(flagOf(k)), 8'(k < 4));
			@(negedge core_clk);
			chk("irq", 8'(irqOut), 8'h00);
			setEn(k, 1'b1);
			if (k == 4) fire(k);
			@(negedge core_clk);
			chk("irq", 8'(irqOut), 8'h01);
			wr(k < 2 ? 2 : 1);
			chk("flag", 8'(flagOf(k)), 8'h01);
			clr(k);
			chk("flag", 8'(flagOf(k)), 8'h00);
			@(negedge core_clk);
			chk("irq", 8'(irqOut), 8'h00);
			setEn(k, 1'b0);
		end
		$display("test interrupt sources done");
		for (int c = 0; c < 8; c++) begin
			shA.xferDoneTimingSel = !c[2];
			wr(1);
			evB.transmitting = c[0];
			evB.firstByte = c[1];
			evB.sclEighth = 1'b1;
			pulse();
			chk("xferEighth", 8'(ctrlBOut.xferDoneFlag), 8'(c == 0));
			evB.transmitting = c[0];
			evB.firstByte = c[1];
			evB.sclNinth = 1'b1;
			pulse();
			chk("xferNinth", 8'(ctrlBOut.xferDoneFlag), 8'h01);
			clr(0);
		end
		$display("test completion timing done");
		shA = 8'hff;
		wr(1);
		shB = 8'h3f;
		wr(2);
		fire(1);
		fire(2);
		shC.opEnable = 1'b0;
		wr(0);
		chk("ctrlA", ctrlAOut, 8'h28);
		chk("ctrlB", ctrlBOut, 8'h03);
		chk("mode", 8'(modeOut), 8'(i2cc_pkg::MODE_OFF));
		fire(2);
		wr(1);
		chk("ctrlA", ctrlAOut, 8'h28);
		chk("irq", 8'(irqOut), 8'h01);
		clkEn = 1'b0;
		irqLevelIn = 2'h2;
		irqLevelWr = 1'b1;
		@(negedge core_clk);
		chk("levelFrozen", 8'(irqLevelOut), 8'h01);
		clkEn = 1'b1;
		@(negedge core_clk);
		irqLevelWr = 1'b0;
		chk("level", 8'(irqLevelOut), 8'h02);
		$display("test disable done");
		wrap_up();
	end
endmodule
`default_nettype wire
